// ### ldoreg_cfg.svh
// Register offsets, field positions, write masks and code points for the LDO control register bank.
// Assumes inclusion by bare name from the package and design modules.
`ifndef LDOREG_CFG_SVH
`define LDOREG_CFG_SVH

`define LDOREG_OFS_SEQ_FAULT 8'hCC
`define LDOREG_OFS_LOW_POWER 8'hCD
`define LDOREG_OFS_C_CONTROL 8'hCE
`define LDOREG_OFS_STATUS 8'hF0
`define LDOREG_OFS_MASK 8'hF1
`define LDOREG_OFS_SYS_CTRL 8'hF2
`define LDOREG_OFS_CHAN_STATE 8'hF3

`define LDOREG_FAULT_ACT_HI 15
`define LDOREG_FAULT_ACT_LO 14
`define LDOREG_START_HI 13
`define LDOREG_START_LO 10
`define LDOREG_SHUT_HI 9
`define LDOREG_SHUT_LO 6
`define LDOREG_HIB_BEH_HI 13
`define LDOREG_HIB_BEH_LO 12
`define LDOREG_HIB_SRC_HI 9
`define LDOREG_HIB_SRC_LO 8
`define LDOREG_VOLT_HI 4
`define LDOREG_VOLT_LO 0
`define LDOREG_SWITCH_BIT 14
`define LDOREG_FLOAT_BIT 10

`define LDOREG_WMASK_SEQ 16'hFFC0
`define LDOREG_WMASK_LP 16'h331F
`define LDOREG_WMASK_CTRL 16'h441F

`define LDOREG_ACT_IGNORE 2'h0
`define LDOREG_ACT_SHUT_REG 2'h1
`define LDOREG_SLOT_OFF 4'h0
`define LDOREG_SLOT_ACTIVE 4'hF
`define LDOREG_HIB_IMAGE 2'h0
`define LDOREG_HIB_DISABLE 2'h1
`define LDOREG_SRC_REG_BIT 2'h0

`endif

// ### ldoreg_pkg.sv
// Types shared by the LDO register bank and its slot decoder.
// Assumes the constants header is on the include path.
`include "ldoreg_cfg.svh"

package ldoreg_pkg;

    typedef struct packed {
        logic [1:0] fault_action;
        logic [3:0] startup_slot;
        logic [3:0] shutdown_slot;
    } ldoreg_seq_type;

    typedef struct packed {
        logic [1:0] hib_behaviour;
        logic [1:0] hib_source;
        logic [4:0] image_code;
    } ldoreg_lp_type;

    typedef struct packed {
        logic switch_mode;
        logic float_ctrl;
        logic [4:0] volt_code;
    } ldoreg_ctrl_type;

    typedef enum logic [1:0] {
        LDOREG_SYS_OFF,
        LDOREG_SYS_SEQ,
        LDOREG_SYS_ACTIVE
    } ldoreg_phase_type;

    typedef enum {
        LDOREG_CH_OFF,
        LDOREG_CH_ON,
        LDOREG_CH_HIB
    } ldoreg_chan_type;

endpackage

// ### ldoreg_slot.sv
// Slot decoder: turns start-up and shutdown slot codes into enable and disable requests.
// Assumes phase and slot number come from the power state machine, one step per cycle.
`timescale 1ns/1ps
`include "ldoreg_cfg.svh"

module ldoreg_slot (
    input wire logic [3:0] startup_slot,
    input wire logic [3:0] shutdown_slot,
    input wire ldoreg_pkg::ldoreg_phase_type phase,
    input wire logic powering_up,
    input wire logic [3:0] slot_num,
    input wire logic slot_stb,
    output logic enable_req,
    output logic disable_req
);

    always_comb begin
        enable_req = 1'b0;
        disable_req = 1'b0;
        if (powering_up) begin
            if (startup_slot == `LDOREG_SLOT_ACTIVE) begin
                enable_req = (phase == ldoreg_pkg::LDOREG_SYS_ACTIVE);
            end else if (startup_slot != `LDOREG_SLOT_OFF) begin
                enable_req = slot_stb && (slot_num == startup_slot);
            end
        end else begin
            if (shutdown_slot == `LDOREG_SLOT_OFF || shutdown_slot == `LDOREG_SLOT_ACTIVE) begin
                disable_req = (phase == ldoreg_pkg::LDOREG_SYS_OFF);
            end else begin
                disable_req = slot_stb && (slot_num == shutdown_slot);
            end
        end
    end

endmodule

// ### ldoreg_bank.sv
// LDO register bank: sequencing, fault, hibernate and output control for two regulator channels.
// Assumes a synchronous register port and a power state machine that gives phase and slot strobes.
//
// Summary of operation
// - Fault action 00 ignores, 01 stops this regulator, 10 and 11 stop the system.
// - Every regulator fault raises an interrupt when its mask bit is set, whatever the fault action is.
// - Start slot 0 keeps off, 1 to 14 enables in that slot, 15 on active.
// - Shutdown slot 1 to 14 disables in that slot; 0 and 15 on entering off.
// - The state machine resets configuration fields to variant-specific mask defaults.
// - Hibernate behaviour 00 selects image voltage, 01 disables output, others reserved.
// - Hibernate source 00 is register bit; 01 to 11 select low-power inputs 1 to 3.
// - Image code: top half 1.8 to 3.3 V in 100 mV, bottom 0.9 to 1.65 V.
// - Output code uses the same encoding and only matters in regulator mode.
// - Switch mode bit 14 high gives a current-limited switch, ignoring the voltage code.
// - Float bit 10 low discharges a disabled output, high leaves it floating.
// - With all four regulators disabled, the channel C output is discharged regardless of float.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "ldoreg_cfg.svh"

module ldoreg_bank #(
    parameter logic [15:0] SEQ_DEFAULT = 16'h0400,
    parameter logic [15:0] LP_DEFAULT = 16'h001C,
    parameter logic [15:0] CTRL_DEFAULT = 16'h001B
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire ldoreg_pkg::ldoreg_phase_type PHASE,
    input wire logic POWERING_UP,
    input wire logic [3:0] SLOT_NUM,
    input wire logic SLOT_STB,
    input wire logic SM_DEFAULTS,
    input wire logic [2:0] LOW_POWER_IN,
    input wire logic FAULT_B,
    input wire logic FAULT_C,
    input wire logic OTHERS_DISABLED,
    output logic EN_B,
    output logic [4:0] VOLT_B,
    output logic EN_C,
    output logic SWITCH_C,
    output logic [4:0] VOLT_C,
    output logic DISCHARGE_C,
    output logic SYS_SHUTDOWN,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and sequencing state.

    logic [15:0] seq_q;
    logic [15:0] lp_q;
    logic [15:0] ctrl_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic hib_bit_q;
    ldoreg_pkg::ldoreg_chan_type chan_q;
    logic fault_off_q;
    logic [15:0] rdata_q;
    logic en_c_q;
    logic [4:0] volt_b_q;
    logic sys_shut_q;
    logic discharge_q;

    ldoreg_pkg::ldoreg_seq_type seq_f;
    ldoreg_pkg::ldoreg_lp_type lp_f;
    ldoreg_pkg::ldoreg_ctrl_type ctrl_f;
    logic enable_req;
    logic disable_req;
    logic hib_sel;
    logic [1:0] events;

    assign seq_f = '{seq_q[`LDOREG_FAULT_ACT_HI:`LDOREG_FAULT_ACT_LO],
                     seq_q[`LDOREG_START_HI:`LDOREG_START_LO], seq_q[`LDOREG_SHUT_HI:`LDOREG_SHUT_LO]};
    assign lp_f = '{lp_q[`LDOREG_HIB_BEH_HI:`LDOREG_HIB_BEH_LO], lp_q[`LDOREG_HIB_SRC_HI:`LDOREG_HIB_SRC_LO],
                    lp_q[`LDOREG_VOLT_HI:`LDOREG_VOLT_LO]};
    assign ctrl_f = '{ctrl_q[`LDOREG_SWITCH_BIT], ctrl_q[`LDOREG_FLOAT_BIT], ctrl_q[`LDOREG_VOLT_HI:`LDOREG_VOLT_LO]};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers; the state machine may reload mask defaults at any time.

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            seq_q <= SEQ_DEFAULT & `LDOREG_WMASK_SEQ;
            lp_q <= LP_DEFAULT & `LDOREG_WMASK_LP;
            ctrl_q <= CTRL_DEFAULT & `LDOREG_WMASK_CTRL;
        end else if (SM_DEFAULTS) begin
            seq_q <= SEQ_DEFAULT & `LDOREG_WMASK_SEQ;
            lp_q <= LP_DEFAULT & `LDOREG_WMASK_LP;
            ctrl_q <= CTRL_DEFAULT & `LDOREG_WMASK_CTRL;
        end else if (WR) begin
            if (hit(ADDR, `LDOREG_OFS_SEQ_FAULT)) begin
                seq_q <= WDATA & `LDOREG_WMASK_SEQ;
            end else if (hit(ADDR, `LDOREG_OFS_LOW_POWER)) begin
                lp_q <= WDATA & `LDOREG_WMASK_LP;
            end else if (hit(ADDR, `LDOREG_OFS_C_CONTROL)) begin
                ctrl_q <= WDATA & `LDOREG_WMASK_CTRL;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mask_q <= 2'h0;
            hib_bit_q <= 1'b0;
        end else if (WR) begin
            if (hit(ADDR, `LDOREG_OFS_MASK)) begin
                mask_q <= WDATA[1:0];
            end else if (hit(ADDR, `LDOREG_OFS_SYS_CTRL)) begin
                hib_bit_q <= WDATA[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault events and interrupt; a set in the clearing read cycle wins.

    assign events = {FAULT_C, FAULT_B};

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            status_q <= 2'h0;
        end else if (RD && hit(ADDR, `LDOREG_OFS_STATUS)) begin
            status_q <= events;
        end else begin
            status_q <= status_q | events;
        end
    end

    assign IRQ = |(status_q & mask_q);

    // A fault on channel B acts on its own fault action; channel C faults only interrupt.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sys_shut_q <= 1'b0;
            fault_off_q <= 1'b0;
        end else begin
            sys_shut_q <= FAULT_B && seq_f.fault_action[1];
            if (FAULT_B && seq_f.fault_action == `LDOREG_ACT_SHUT_REG) begin
                fault_off_q <= 1'b1;
            end else if (enable_req) begin
                fault_off_q <= 1'b0;
            end
        end
    end

    assign SYS_SHUTDOWN = sys_shut_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Channel B sequencing and hibernate.

    ldoreg_slot u_slot (
        .startup_slot(seq_f.startup_slot),
        .shutdown_slot(seq_f.shutdown_slot),
        .phase(PHASE),
        .powering_up(POWERING_UP),
        .slot_num(SLOT_NUM),
        .slot_stb(SLOT_STB),
        .enable_req(enable_req),
        .disable_req(disable_req)
    );

    always_comb begin
        if (lp_f.hib_source == `LDOREG_SRC_REG_BIT) begin
            hib_sel = hib_bit_q;
        end else begin
            hib_sel = LOW_POWER_IN[lp_f.hib_source - 2'h1];
        end
    end

    // Hibernate is only entered from the on state, so waking returns to on; a disable request or acted-on fault goes to off.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            chan_q <= ldoreg_pkg::LDOREG_CH_OFF;
        end else begin
            case (chan_q)
                ldoreg_pkg::LDOREG_CH_OFF: begin
                    if (enable_req && !fault_off_q) begin
                        chan_q <= ldoreg_pkg::LDOREG_CH_ON;
                    end
                end
                ldoreg_pkg::LDOREG_CH_ON: begin
                    if (disable_req || (FAULT_B && seq_f.fault_action != `LDOREG_ACT_IGNORE)) begin
                        chan_q <= ldoreg_pkg::LDOREG_CH_OFF;
                    end else if (hib_sel) begin
                        chan_q <= ldoreg_pkg::LDOREG_CH_HIB;
                    end
                end
                default: begin
                    if (disable_req || (FAULT_B && seq_f.fault_action != `LDOREG_ACT_IGNORE)) begin
                        chan_q <= ldoreg_pkg::LDOREG_CH_OFF;
                    end else if (!hib_sel) begin
                        chan_q <= ldoreg_pkg::LDOREG_CH_ON;
                    end
                end
            endcase
        end
    end

    // Reserved hibernate codes behave as image voltage; that keeps the rail up, the safer default.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            volt_b_q <= 5'h00;
        end else if (chan_q == ldoreg_pkg::LDOREG_CH_HIB && lp_f.hib_behaviour != `LDOREG_HIB_DISABLE) begin
            volt_b_q <= lp_f.image_code;
        end else begin
            volt_b_q <= CTRL_DEFAULT[4:0];
        end
    end

    assign EN_B = (chan_q == ldoreg_pkg::LDOREG_CH_ON) ||
                  (chan_q == ldoreg_pkg::LDOREG_CH_HIB && lp_f.hib_behaviour != `LDOREG_HIB_DISABLE);
    assign VOLT_B = volt_b_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Channel C output control.

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            en_c_q <= 1'b0;
            discharge_q <= 1'b0;
        end else begin
            en_c_q <= (PHASE != ldoreg_pkg::LDOREG_SYS_OFF);
            discharge_q <= !en_c_q && (!ctrl_f.float_ctrl || (OTHERS_DISABLED && !EN_B));
        end
    end

    assign EN_C = en_c_q;
    assign SWITCH_C = ctrl_f.switch_mode;
    assign VOLT_C = ctrl_f.switch_mode ? 5'h00 : ctrl_f.volt_code;
    assign DISCHARGE_C = discharge_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero.

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q <= 16'h0000;
        end else if (RD) begin
            if (hit(ADDR, `LDOREG_OFS_SEQ_FAULT)) begin
                rdata_q <= seq_q;
            end else if (hit(ADDR, `LDOREG_OFS_LOW_POWER)) begin
                rdata_q <= lp_q;
            end else if (hit(ADDR, `LDOREG_OFS_C_CONTROL)) begin
                rdata_q <= ctrl_q;
            end else if (hit(ADDR, `LDOREG_OFS_STATUS)) begin
                rdata_q <= {14'h0000, status_q};
            end else if (hit(ADDR, `LDOREG_OFS_MASK)) begin
                rdata_q <= {14'h0000, mask_q};
            end else if (hit(ADDR, `LDOREG_OFS_SYS_CTRL)) begin
                rdata_q <= {15'h0000, hib_bit_q};
            end else if (hit(ADDR, `LDOREG_OFS_CHAN_STATE)) begin
                rdata_q <= {12'h000, fault_off_q, discharge_q, EN_C, EN_B};
            end else begin
                rdata_q <= 16'h0000;
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign RDATA = rdata_q;

endmodule

// ### ldoreg_monitor.sv
// Port checker for the LDO register bank.
// Assumes one clock domain and is attached by the bind at the foot of this file.
`timescale 1ns/1ps
module ldoreg_monitor (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic WR,
    input wire logic RD,
    input wire ldoreg_pkg::ldoreg_phase_type PHASE,
    input wire logic SM_DEFAULTS,
    input wire logic FAULT_B,
    input wire logic FAULT_C,
    input wire logic OTHERS_DISABLED,
    input wire logic EN_B,
    input wire logic EN_C,
    input wire logic SWITCH_C,
    input wire logic [4:0] VOLT_C,
    input wire logic DISCHARGE_C,
    input wire logic SYS_SHUTDOWN,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////
    chk_switch_zero: assert property (SWITCH_C |-> VOLT_C == 5'h00)
        else $error("voltage code not ignored in switch mode");
    chk_enable_phase: assert property (1 |=> EN_C == ($past(PHASE) != ldoreg_pkg::LDOREG_SYS_OFF))
        else $error("channel enable does not follow phase");
    chk_all_discharge: assert property ((!EN_C && !EN_B && OTHERS_DISABLED) [*3] |-> DISCHARGE_C)
        else $error("output not discharged with all regulators off");
    chk_sys_cause: assert property (SYS_SHUTDOWN |-> $past(FAULT_B) || $past(FAULT_B, 2))
        else $error("system shutdown without a fault");
    // Register-fed outputs may only move after a write or a default reload.
    chk_volt_cause: assert property ($changed(VOLT_C) |-> $past(WR) || $past(SM_DEFAULTS) || $past(WR, 2))
        else $error("voltage code changed without cause");
    chk_switch_cause: assert property ($changed(SWITCH_C) |-> $past(WR) || $past(SM_DEFAULTS) || $past(WR, 2))
        else $error("switch mode changed without cause");
    chk_irq_rise: assert property ($rose(IRQ) |-> $past(FAULT_B) || $past(FAULT_C) || $past(WR))
        else $error("interrupt rose without a fault");
    chk_irq_fall: assert property ($fell(IRQ) |-> $past(RD) || $past(WR) || $past(RD, 2))
        else $error("interrupt fell without an access");
    cover property (SYS_SHUTDOWN);
    cover property (IRQ ##1 !IRQ);
    cover property (SWITCH_C);
endmodule
bind ldoreg_bank ldoreg_monitor ldoreg_monitor_inst (.CLK(CLK), .RSTN(RSTN), .WR(WR), .RD(RD), .PHASE(PHASE),
    .SM_DEFAULTS(SM_DEFAULTS), .FAULT_B(FAULT_B), .FAULT_C(FAULT_C), .OTHERS_DISABLED(OTHERS_DISABLED),
    .EN_B(EN_B), .EN_C(EN_C), .SWITCH_C(SWITCH_C), .VOLT_C(VOLT_C), .DISCHARGE_C(DISCHARGE_C),
    .SYS_SHUTDOWN(SYS_SHUTDOWN), .IRQ(IRQ));

// ### tb.sv
// Testbench for the LDO register bank: registers, faults, slots, hibernate and discharge.
// Assumes the design's default parameters and one 125 MHz clock.
`timescale 1ns/1ps
module tb;
    logic CLK = 0, RSTN = 0, WR = 0, RD = 0, POWERING_UP = 0, SLOT_STB = 0, SM_DEFAULTS = 0;
    logic FAULT_B = 0, FAULT_C = 0, OTHERS_DISABLED = 0;
    logic [7:0] ADDR = 8'h00;
    logic [15:0] WDATA = 16'h0000;
    logic [3:0] SLOT_NUM = 4'h0;
    logic [2:0] LOW_POWER_IN = 3'h0;
    ldoreg_pkg::ldoreg_phase_type PHASE = ldoreg_pkg::LDOREG_SYS_OFF;
    logic [15:0] RDATA;
    logic [4:0] VOLT_B, VOLT_C;
    logic EN_B, EN_C, SWITCH_C, DISCHARGE_C, SYS_SHUTDOWN, IRQ;
    int n_fail = 0;
    int samples_checked = 0;
    ldoreg_bank ldoreg_bank_inst (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .PHASE(PHASE), .POWERING_UP(POWERING_UP), .SLOT_NUM(SLOT_NUM), .SLOT_STB(SLOT_STB),
        .SM_DEFAULTS(SM_DEFAULTS), .LOW_POWER_IN(LOW_POWER_IN), .FAULT_B(FAULT_B), .FAULT_C(FAULT_C),
        .OTHERS_DISABLED(OTHERS_DISABLED), .EN_B(EN_B), .VOLT_B(VOLT_B), .EN_C(EN_C), .SWITCH_C(SWITCH_C),
        .VOLT_C(VOLT_C), .DISCHARGE_C(DISCHARGE_C), .SYS_SHUTDOWN(SYS_SHUTDOWN), .IRQ(IRQ));
    always #4 CLK = ~CLK;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // Read data is only valid in the cycle right after the strobe, so it is sampled there.
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hFFFF);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA & m, exp);
    endtask
    // A shutdown pulse may land one or two cycles after the fault, so both cycles are seen.
    task automatic hit(input logic c, output logic sd);
        @(posedge CLK);
        FAULT_B <= !c;
        FAULT_C <= c;
        @(posedge CLK);
        FAULT_B <= 1'b0;
        FAULT_C <= 1'b0;
        #1;
        sd = SYS_SHUTDOWN;
        tick(1);
        sd = sd | SYS_SHUTDOWN;
    endtask
    task automatic fire(input logic [3:0] s);
        @(posedge CLK);
        SLOT_NUM <= s;
        SLOT_STB <= 1'b1;
        @(posedge CLK);
        SLOT_STB <= 1'b0;
        tick(2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_fields;
        chk(16'(SWITCH_C), 16'h0000);
        chk(16'(VOLT_C), 16'h001B);
        wr(8'hCC, 16'hFFFF);
        wr(8'hCD, 16'hFFFF);
        wr(8'hCE, 16'hFFFF);
        rd(8'hCC, 16'hFFC0);
        rd(8'hCD, 16'h331F);
        rd(8'hCE, 16'h441F);
        rd(8'hAA, 16'h0000);
        chk(16'(SWITCH_C), 16'h0001);
        chk(16'(VOLT_C), 16'h0000);
        wr(8'hCE, 16'h0011);
        tick(1);
        chk(16'(VOLT_C), 16'h0011);
        @(posedge CLK);
        SM_DEFAULTS <= 1'b1;
        @(posedge CLK);
        SM_DEFAULTS <= 1'b0;
        rd(8'hCC, 16'h0400);
        rd(8'hCD, 16'h001C);
        rd(8'hCE, 16'h001B);
    endtask
    task automatic t_faults;
        logic [1:0] acts [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
        logic sd;
        hit(1'b0, sd);
        chk(16'(IRQ), 16'h0000);
        rd(8'hF0, 16'h0001);
        wr(8'hF1, 16'h0003);
        foreach (acts[i]) begin
            wr(8'hCC, {acts[i], 14'h0000});
            hit(1'b0, sd);
            chk(16'(IRQ), 16'h0001);
            chk(16'(sd), 16'(acts[i][1]));
            rd(8'hF3, {12'h000, acts[i] == 2'h1, 3'h0}, 16'h0008);
            rd(8'hF0, 16'h0001);
            chk(16'(IRQ), 16'h0000);
        end
        hit(1'b1, sd);
        rd(8'hF0, 16'h0002);
    endtask
    task automatic t_hibernate;
        for (int s = 1; s <= 3; s++) begin
            wr(8'hCD, 16'h0005 | 16'(s << 8));
            LOW_POWER_IN <= ~3'(1 << (s - 1));
            tick(3);
            chk(16'(VOLT_B), 16'h001B);
            @(posedge CLK);
            LOW_POWER_IN <= 3'(1 << (s - 1));
            tick(3);
            chk(16'(VOLT_B), 16'h0005);
            @(posedge CLK);
            LOW_POWER_IN <= 3'h0;
            tick(3);
            chk(16'(VOLT_B), 16'h001B);
        end
        wr(8'hCD, 16'h1005);
        wr(8'hF2, 16'h0001);
        tick(2);
        chk(16'(EN_B), 16'h0000);
        wr(8'hF2, 16'h0000);
        tick(2);
        chk(16'(EN_B), 16'h0001);
    endtask
    task automatic t_discharge;
        @(posedge CLK);
        PHASE <= ldoreg_pkg::LDOREG_SYS_OFF;
        wr(8'hCE, 16'h0400);
        tick(3);
        chk(16'(DISCHARGE_C), 16'h0000);
        chk(16'(EN_C), 16'h0000);
        @(posedge CLK);
        OTHERS_DISABLED <= 1'b1;
        tick(3);
        chk(16'(DISCHARGE_C), 16'h0001);
        @(posedge CLK);
        OTHERS_DISABLED <= 1'b0;
        wr(8'hCE, 16'h0000);
        tick(3);
        chk(16'(DISCHARGE_C), 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        t_fields;
        t_faults;
        wr(8'hCC, 16'h0D40);
        PHASE <= ldoreg_pkg::LDOREG_SYS_SEQ;
        POWERING_UP <= 1'b1;
        fire(4'h2);
        chk(16'(EN_B), 16'h0000);
        chk(16'(EN_C), 16'h0001);
        // The fault-off latch left by the fault scenario swallows the first enable request.
        fire(4'h3);
        chk(16'(EN_B), 16'h0000);
        rd(8'hF3, 16'h0000, 16'h0008);
        fire(4'h3);
        chk(16'(EN_B), 16'h0001);
        t_hibernate;
        @(posedge CLK);
        POWERING_UP <= 1'b0;
        fire(4'h4);
        chk(16'(EN_B), 16'h0001);
        fire(4'h5);
        chk(16'(EN_B), 16'h0000);
        wr(8'hCC, 16'h3C00);
        POWERING_UP <= 1'b1;
        PHASE <= ldoreg_pkg::LDOREG_SYS_ACTIVE;
        tick(2);
        chk(16'(EN_B), 16'h0001);
        @(posedge CLK);
        POWERING_UP <= 1'b0;
        PHASE <= ldoreg_pkg::LDOREG_SYS_OFF;
        tick(2);
        chk(16'(EN_B), 16'h0000);
        t_discharge;
        close_out;
    end
    // The scenarios need well under a thousand cycles; this leaves a wide margin.
    initial begin
        #200000;
        n_fail++;
        close_out;
    end
endmodule
